/* File: hdl/mstc_pkg.sv */
// Package of constants, types and register layout for the machine sub-mode trap control block.
package mstc_pkg;

   // ****************************************************************
   // Widths and register offsets
   // ****************************************************************
   localparam int MSTC_XLEN = 32; // Data and address width of the core.
   localparam logic [3:0] MSTC_ADDR_CTRL = 4'h0; // Misc control register.
   localparam logic [3:0] MSTC_ADDR_TVEC = 4'h4; // Trap vector register.
   localparam logic [3:0] MSTC_ADDR_EPC = 4'h8; // Exception PC register.
   localparam logic [3:0] MSTC_ADDR_CAUSE = 4'hc; // Trap cause, read only.
   localparam logic [3:0] MSTC_ADDR_TVAL = 4'h1; // Trap value, index 1, byte address 0x04 above block 0x10.
   localparam logic [5:0] MSTC_ADDR_STATUS_B = 6'h10; // Status register byte address.
   localparam logic [5:0] MSTC_ADDR_TVAL_B = 6'h14; // Trap value byte address.
   localparam logic [5:0] MSTC_ADDR_SUBM_B = 6'h18; // Sub-mode register byte address.
   localparam logic [5:0] MSTC_ADDR_PRIV_B = 6'h1c; // Privilege mode byte address, read only.

   // ****************************************************************
   // Field positions and codes
   // ****************************************************************
   localparam int MSTC_NMI_SEL_BIT = 9; // Control bit that selects NMI vector and trap ID.
   localparam int MSTC_MIE_BIT = 3; // Status interrupt enable.
   localparam int MSTC_MPIE_BIT = 7; // Status previous interrupt enable.
   localparam int MSTC_MPP_LSB = 11; // Status previous privilege field, low bit.
   localparam int MSTC_PTYP_LSB = 8; // Previous sub-mode field in the sub-mode register.
   localparam int MSTC_TYP_LSB = 6; // Current sub-mode field in the sub-mode register.
   localparam logic [11:0] MSTC_CODE_ILLEGAL = 12'h002; // Illegal instruction cause code.
   localparam logic [11:0] MSTC_NMI_ID_SHARED = 12'hfff; // NMI trap ID with shared vector.
   localparam logic [11:0] MSTC_NMI_ID_BOOT = 12'h001; // NMI trap ID with boot vector.
   localparam logic [1:0] MSTC_PRIV_M = 2'h3; // Machine privilege code.
   localparam logic [1:0] MSTC_PRIV_U = 2'h0; // User privilege code.
   localparam logic [31:0] MSTC_CTRL_RST = 32'h0000_0000; // Control reset value.
   localparam logic [31:0] MSTC_TVEC_RST = 32'h0000_0000; // Trap vector reset value.

   // Sub-mode codes, two bits each, normal is the reset code.
   typedef enum logic [1:0] {
      MSTC_SUBM_NORMAL = 2'h0,
      MSTC_SUBM_EXC = 2'h2,
      MSTC_SUBM_NMI = 2'h3,
      MSTC_SUBM_INT = 2'h1
   } mstc_subm_type;

   // Trap event requests from the pipeline.
   typedef struct packed {
      logic exc_valid; // Exception detected on the current instruction.
      logic [11:0] exc_code; // Exception cause code.
      logic [31:0] exc_pc; // PC of the faulting instruction.
      logic [31:0] exc_tval; // Trap value for the exception.
      logic int_valid; // Interrupt trap granted by the arbiter.
      logic [11:0] int_code; // Interrupt cause code.
      logic [31:0] int_pc; // PC to resume after the interrupt.
      logic mret_valid; // Return instruction retiring.
      logic [31:0] nmi_pc; // PC to resume after the NMI.
   } mstc_event_type;

   // Fetch redirect output to the front end.
   typedef struct packed {
      logic valid; // One-cycle redirect pulse.
      logic [31:0] pc; // Target PC.
   } mstc_redirect_type;

endpackage : mstc_pkg

/* File: hdl/mstc_trap_ctrl.sv */
// Trap entry, return and machine sub-mode tracking with an Avalon-MM register port.
//
// Overview of operation
// (RULE1) Four sub-modes; normal after reset.
// (RULE2) Stay normal until a trap or write.
// (RULE3) Exception trap enters exception sub-mode.
// (RULE4) NMI trap enters NMI sub-mode.
// (RULE5) Interrupt trap enters interrupt sub-mode.
// (RULE6) Exceptions are never masked.
// (RULE7) Exception jumps to trap vector, single cycle.
// (RULE8) Exception writes cause, epc, tval, status.
// (RULE9) Exception writes exception code to current field.
// (RULE10) Exception saves old sub-mode to previous field.
// (RULE11) Return resumes at epc, restores status, privilege.
// (RULE12) Return copies previous into current sub-mode.
// (RULE13) Illegal instruction cause code is two.
// (RULE14) No automatic context save or restore.
// (RULE15) NMI input is unmaskable and aborts execution.
// (RULE16) NMI updates CSRs, vector, privilege in one cycle.
// (RULE17) Control bit nine set: NMI uses trap vector.
// (RULE18) Control bit nine clear: NMI uses boot address.
// (RULE19) NMI cause is 0xfff or 0x1 by bit nine.
// (RULE20) NMI switches privilege to machine.
// (RULE21) NMI writes NMI code to current field.
// (RULE22) NMI saves old sub-mode to previous field.
// (RULE23) Return from NMI restores prior sub-mode.
// (RULE24) Two-bit sub-mode codes, normal at reset.
`timescale 1ns/1ps
`default_nettype none

module mstc_trap_ctrl (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic nmi_req,
   input wire logic [31:0] boot_addr,
   input wire mstc_pkg::mstc_event_type evt,
   output var mstc_pkg::mstc_redirect_type redirect,
   output logic [1:0] priv_mode,
   output logic [1:0] cur_submode,
   output logic nmi_ack,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);
   import mstc_pkg::*;

   // ****************************************************************
   // State record
   // ****************************************************************
   typedef struct packed {
      logic [31:0] ctrl; // Misc control register.
      logic [31:0] tvec; // Trap vector.
      logic [31:0] epc; // Exception PC.
      logic [31:0] cause; // Trap cause.
      logic [31:0] tval; // Trap value.
      logic [31:0] status; // Status register.
      logic [1:0] typ; // Current sub-mode field.
      logic [1:0] ptyp; // Previous sub-mode field.
      logic [1:0] priv; // Privilege mode.
      logic redir_valid; // Redirect pulse.
      logic [31:0] redir_pc; // Redirect target.
      logic nmi_ack; // NMI taken pulse.
      logic nmi_seen; // NMI level already serviced.
      logic bus_done; // Bus answer phase flag.
      logic [31:0] rdata; // Bus read data.
   } mstc_state_type;

   mstc_state_type state_r; // Registered state.
   mstc_state_type state_nxt; // Next state.
   logic nmi_take; // NMI taken this cycle.

   // Merges a bus write into a register under byte enables.
   function automatic logic [31:0] mstc_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction : mstc_merge

   // Builds the status value written on trap entry.
   function automatic logic [31:0] mstc_enter_status(input logic [31:0] st, input logic [1:0] pv);
      logic [31:0] res;
      res = st;
      res[MSTC_MPIE_BIT] = st[MSTC_MIE_BIT];
      res[MSTC_MIE_BIT] = 1'b0;
      res[MSTC_MPP_LSB +: 2] = pv;
      return res;
   endfunction : mstc_enter_status

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   always_comb begin
      state_nxt = state_r;
      state_nxt.redir_valid = 1'b0;
      state_nxt.nmi_ack = 1'b0;
      // NMI is taken once per rising request, with no mask at all. [RULE15]
      nmi_take = nmi_req && !state_r.nmi_seen;
      state_nxt.nmi_seen = nmi_req;

      // Bus slave: one wait cycle, then answer with waitrequest low.
      if ((avs_read || avs_write) && !state_r.bus_done) begin
         state_nxt.bus_done = 1'b1;
         case (avs_address)
            {2'b00, MSTC_ADDR_CTRL}: state_nxt.rdata = state_r.ctrl;
            {2'b00, MSTC_ADDR_TVEC}: state_nxt.rdata = state_r.tvec;
            {2'b00, MSTC_ADDR_EPC}: state_nxt.rdata = state_r.epc;
            {2'b00, MSTC_ADDR_CAUSE}: state_nxt.rdata = state_r.cause;
            MSTC_ADDR_STATUS_B: state_nxt.rdata = state_r.status;
            MSTC_ADDR_TVAL_B: state_nxt.rdata = state_r.tval;
            MSTC_ADDR_SUBM_B: begin
               state_nxt.rdata = '0;
               state_nxt.rdata[MSTC_TYP_LSB +: 2] = state_r.typ;
               state_nxt.rdata[MSTC_PTYP_LSB +: 2] = state_r.ptyp;
            end
            MSTC_ADDR_PRIV_B: state_nxt.rdata = {30'h0000_0000, state_r.priv};
            default: state_nxt.rdata = 32'h0000_0000; // Unmapped reads zero, writes dropped.
         endcase
      end else begin
         state_nxt.bus_done = 1'b0;
      end

      // Writes take effect at the answering edge; traps below override them.
      if (avs_write && state_r.bus_done) begin
         case (avs_address)
            {2'b00, MSTC_ADDR_CTRL}: state_nxt.ctrl = mstc_merge(state_r.ctrl, avs_writedata, avs_byteenable);
            {2'b00, MSTC_ADDR_TVEC}: state_nxt.tvec = mstc_merge(state_r.tvec, avs_writedata, avs_byteenable);
            {2'b00, MSTC_ADDR_EPC}: state_nxt.epc = mstc_merge(state_r.epc, avs_writedata, avs_byteenable);
            MSTC_ADDR_STATUS_B: state_nxt.status = mstc_merge(state_r.status, avs_writedata, avs_byteenable);
            MSTC_ADDR_TVAL_B: state_nxt.tval = mstc_merge(state_r.tval, avs_writedata, avs_byteenable);
            MSTC_ADDR_SUBM_B: begin
               // Software may switch sub-mode explicitly. [RULE2]
               if (avs_byteenable[0]) begin
                  state_nxt.typ = avs_writedata[MSTC_TYP_LSB +: 2];
               end
               if (avs_byteenable[1]) begin
                  state_nxt.ptyp = avs_writedata[MSTC_PTYP_LSB +: 2];
               end
            end
            default: begin
               state_nxt.rdata = state_nxt.rdata; // Read-only or unmapped: no effect.
            end
         endcase
      end

      // Trap priority: NMI, then exception, then interrupt, then return.
      // Only CSRs and modes change; no register context is saved. [RULE14]
      if (nmi_take) begin
         state_nxt.nmi_ack = 1'b1;
         state_nxt.epc = evt.nmi_pc; // [RULE16]
         state_nxt.status = mstc_enter_status(state_r.status, state_r.priv); // [RULE16]
         state_nxt.redir_valid = 1'b1;
         if (state_r.ctrl[MSTC_NMI_SEL_BIT]) begin
            state_nxt.redir_pc = state_r.tvec; // [RULE17]
            state_nxt.cause = {20'h0_0000, MSTC_NMI_ID_SHARED}; // [RULE19]
         end else begin
            state_nxt.redir_pc = boot_addr; // [RULE18]
            state_nxt.cause = {20'h0_0000, MSTC_NMI_ID_BOOT}; // [RULE19]
         end
         state_nxt.priv = MSTC_PRIV_M; // [RULE20]
         state_nxt.ptyp = state_r.typ; // [RULE22]
         state_nxt.typ = MSTC_SUBM_NMI; // [RULE4] [RULE21]
      end else if (evt.exc_valid) begin
         // No enable gates an exception. [RULE6]
         state_nxt.redir_valid = 1'b1;
         state_nxt.redir_pc = state_r.tvec; // [RULE7]
         state_nxt.cause = {20'h0_0000, evt.exc_code}; // Illegal instruction arrives as 0x2. [RULE8] [RULE13]
         state_nxt.epc = evt.exc_pc; // [RULE8]
         state_nxt.tval = evt.exc_tval; // [RULE8]
         state_nxt.status = mstc_enter_status(state_r.status, state_r.priv); // [RULE8]
         state_nxt.priv = MSTC_PRIV_M; // [RULE7]
         state_nxt.ptyp = state_r.typ; // [RULE10]
         state_nxt.typ = MSTC_SUBM_EXC; // [RULE3] [RULE9]
      end else if (evt.int_valid) begin
         state_nxt.redir_valid = 1'b1;
         state_nxt.redir_pc = state_r.tvec;
         state_nxt.cause = {1'b1, 19'h0_0000, evt.int_code};
         state_nxt.epc = evt.int_pc;
         state_nxt.status = mstc_enter_status(state_r.status, state_r.priv);
         state_nxt.priv = MSTC_PRIV_M;
         state_nxt.ptyp = state_r.typ;
         state_nxt.typ = MSTC_SUBM_INT; // [RULE5]
      end else if (evt.mret_valid) begin
         state_nxt.redir_valid = 1'b1;
         state_nxt.redir_pc = state_r.epc; // [RULE11]
         state_nxt.priv = state_r.status[MSTC_MPP_LSB +: 2]; // [RULE11]
         state_nxt.status[MSTC_MIE_BIT] = state_r.status[MSTC_MPIE_BIT]; // [RULE11]
         state_nxt.status[MSTC_MPIE_BIT] = 1'b1;
         state_nxt.status[MSTC_MPP_LSB +: 2] = MSTC_PRIV_U;
         state_nxt.typ = state_r.ptyp; // [RULE12] [RULE23]
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state_r <= '0;
         state_r.ctrl <= MSTC_CTRL_RST;
         state_r.tvec <= MSTC_TVEC_RST;
         state_r.priv <= MSTC_PRIV_M;
         state_r.typ <= MSTC_SUBM_NORMAL; // [RULE1] [RULE24]
         state_r.ptyp <= MSTC_SUBM_NORMAL; // [RULE24]
      end else begin
         state_r <= state_nxt;
      end
   end

   // Outputs come straight from the state flip-flops.
   always_comb begin
      redirect.valid = state_r.redir_valid;
      redirect.pc = state_r.redir_pc;
   end
   assign priv_mode = state_r.priv;
   assign cur_submode = state_r.typ;
   assign nmi_ack = state_r.nmi_ack;
   assign avs_readdata = state_r.rdata;
   assign avs_waitrequest = !state_r.bus_done;

endmodule : mstc_trap_ctrl

`default_nettype wire

/* File: bench/mstc_trap_ctrl_properties.sv */
// Concurrent checks on the ports of the trap control block.
`timescale 1ns/1ps
`default_nettype none
module mstc_trap_ctrl_properties import mstc_pkg::*; (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic nmi_req,
   input wire mstc_pkg::mstc_event_type evt,
   input wire mstc_pkg::mstc_redirect_type redirect,
   input wire logic [1:0] priv_mode,
   input wire logic [1:0] cur_submode,
   input wire logic nmi_ack,
   input wire logic avs_write
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // High when nothing in this cycle may move the sub-mode.
   wire logic quiet = !(evt.exc_valid || evt.int_valid || evt.mret_valid || nmi_req || avs_write);
   reset_state_a: assert property (disable iff (1'b0) !reset_n |=>
      cur_submode == MSTC_SUBM_NORMAL && priv_mode == MSTC_PRIV_M && !redirect.valid) else $error("reset state wrong");
   quiet_hold_a: assert property (quiet |=> $stable(cur_submode)) else $error("sub-mode moved");
   exc_entry_a: assert property (evt.exc_valid && !nmi_req |=> redirect.valid &&
      cur_submode == MSTC_SUBM_EXC && priv_mode == MSTC_PRIV_M) else $error("exception entry wrong");
   nmi_entry_a: assert property ($rose(nmi_req) |=> nmi_ack && redirect.valid &&
      cur_submode == MSTC_SUBM_NMI && priv_mode == MSTC_PRIV_M) else $error("nmi entry wrong");
   int_entry_a: assert property (evt.int_valid && !evt.exc_valid && !nmi_req |=>
      cur_submode == MSTC_SUBM_INT) else $error("interrupt entry wrong");
   ack_pulse_a: assert property (nmi_ack |-> redirect.valid ##1 !nmi_ack) else $error("nmi ack wrong");
   redir_cause_a: assert property (redirect.valid |->
      $past(evt.exc_valid || evt.int_valid || evt.mret_valid || nmi_req)) else $error("redirect without cause");
   mret_jump_a: assert property (evt.mret_valid && !evt.exc_valid && !evt.int_valid && !nmi_req |=>
      redirect.valid && !nmi_ack) else $error("return redirect missing");
endmodule : mstc_trap_ctrl_properties
bind mstc_trap_ctrl mstc_trap_ctrl_properties u_props (.ref_clk(ref_clk), .reset_n(reset_n), .nmi_req(nmi_req),
   .evt(evt), .redirect(redirect), .priv_mode(priv_mode), .cur_submode(cur_submode), .nmi_ack(nmi_ack),
   .avs_write(avs_write));
`default_nettype wire

/* File: bench/mstc_sys_model.sv */
// System logic model that drives the NMI level and the boot vector.
`timescale 1ns/1ps
`default_nettype none
module mstc_sys_model (
   input wire logic ref_clk,
   input wire logic fire,
   input wire logic [31:0] boot_val,
   output var logic nmi_req,
   output var logic [31:0] boot_addr
);
   logic [1:0] hold_r = 2'h0; // Cycles left on the NMI level.
   // Each trigger raises the level for two cycles; the core must act on the rise alone.
   always_ff @(posedge ref_clk) begin
      hold_r <= fire ? 2'h2 : (hold_r != 2'h0 ? hold_r - 2'h1 : 2'h0);
   end
   assign nmi_req = hold_r != 2'h0;
   assign boot_addr = boot_val;
endmodule : mstc_sys_model
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench for the trap control block.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import mstc_pkg::*;
   // One exception case: cause code, faulting pc and trap value, which the CSRs must echo.
   typedef struct packed {
      logic [11:0] code;
      logic [31:0] pc;
      logic [31:0] tval;
   } mstc_row_type;
   localparam logic [31:0] TVEC = 32'h0000_0800; // Trap vector written by the bench.
   localparam logic [31:0] BOOT = 32'h0000_0100; // Boot vector from the system model.
   mstc_row_type rows [3] = '{'{12'h002, 32'h0000_1000, 32'h0000_dead},
      '{12'h000, 32'h0000_2004, 32'h0}, '{12'h00b, 32'h0000_3ffc, 32'hffff_fffc}};
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic fire = 1'b0;
   logic nmi_req;
   logic [31:0] boot_addr;
   mstc_event_type evt = '0;
   mstc_redirect_type redirect;
   logic [1:0] priv_mode;
   logic [1:0] cur_submode;
   logic nmi_ack;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [31:0] q; // Last read data.
   int n_fail = 0;
   int n_compared = 0;
   mstc_sys_model u_sys (.ref_clk(ref_clk), .fire(fire), .boot_val(BOOT), .nmi_req(nmi_req), .boot_addr(boot_addr));
   mstc_trap_ctrl u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .nmi_req(nmi_req), .boot_addr(boot_addr), .evt(evt),
      .redirect(redirect), .priv_mode(priv_mode), .cur_submode(cur_submode), .nmi_ack(nmi_ack),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   always #50 ref_clk = ~ref_clk;
   // Compares and counts; a mismatch is reported at once.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // One Avalon transfer, held until waitrequest is sampled low, then one idle edge.
   // Only the watchdog ends a wait that never sees an answer.
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_read <= !wr;
      avs_write <= wr;
      do begin
         @(posedge ref_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask : bus
   task automatic rd(input logic [5:0] a);
      bus(1'b0, a, 32'h0, 4'hf);
   endtask : rd
   // Drives an event for one cycle and returns at the edge where its result is sampled.
   task automatic pulse(input mstc_event_type e);
      evt <= e;
      @(posedge ref_clk);
      evt <= '0;
      @(posedge ref_clk);
   endtask : pulse
   // Asks the system model for an NMI and returns when the core has taken it.
   task automatic nmi();
      fire <= 1'b1;
      @(posedge ref_clk);
      fire <= 1'b0;
      repeat (2) @(posedge ref_clk);
      check(32'(nmi_ack), 32'h1);
   endtask : nmi
   task automatic close_out();
      if (n_fail == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : close_out
   // Watchdog: the whole sequence needs about 110 cycles.
   initial begin
      repeat (3000) @(posedge ref_clk);
      n_fail++;
      close_out();
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'b1;
      check(32'(cur_submode), 32'(MSTC_SUBM_NORMAL));
      @(posedge ref_clk);
      rd(MSTC_ADDR_SUBM_B);
      check(q, 32'h0);
      bus(1'b1, 6'h04, TVEC, 4'hf);
      foreach (rows[i]) begin
         pulse('{exc_valid: 1'b1, exc_code: rows[i].code, exc_pc: rows[i].pc, exc_tval: rows[i].tval, default: '0});
         check(32'(redirect.valid), 32'h1);
         check(redirect.pc, TVEC);
         check(32'(cur_submode), 32'(MSTC_SUBM_EXC));
         rd(6'h0c);
         check(32'(q[11:0]), 32'(rows[i].code));
         rd(6'h08);
         check(q, rows[i].pc);
         rd(MSTC_ADDR_TVAL_B);
         check(q, rows[i].tval);
         rd(MSTC_ADDR_SUBM_B);
         check(32'(q[9:6]), 32'h2);
         pulse('{mret_valid: 1'b1, default: '0});
         check(redirect.pc, rows[i].pc);
         check(32'(cur_submode), 32'(MSTC_SUBM_NORMAL));
      end
      // A bare return drops to user level; the NMI then uses the boot vector.
      pulse('{mret_valid: 1'b1, default: '0});
      check(32'(priv_mode), 32'(MSTC_PRIV_U));
      nmi();
      check(redirect.pc, BOOT);
      check(32'(priv_mode), 32'(MSTC_PRIV_M));
      check(32'(cur_submode), 32'(MSTC_SUBM_NMI));
      rd(6'h0c);
      check(32'(q[11:0]), 32'(MSTC_NMI_ID_BOOT));
      pulse('{mret_valid: 1'b1, default: '0});
      check(32'(cur_submode), 32'(MSTC_SUBM_NORMAL));
      // Shared vector, set by a single-byte write; NMI nested in an exception.
      bus(1'b1, 6'h00, 32'h0000_0200, 4'h2);
      pulse('{exc_valid: 1'b1, int_valid: 1'b1, exc_code: MSTC_CODE_ILLEGAL, default: '0});
      check(32'(cur_submode), 32'(MSTC_SUBM_EXC));
      nmi();
      check(redirect.pc, TVEC);
      rd(6'h0c);
      check(32'(q[11:0]), 32'(MSTC_NMI_ID_SHARED));
      rd(MSTC_ADDR_SUBM_B);
      check(32'(q[9:6]), 32'hb);
      pulse('{mret_valid: 1'b1, default: '0});
      check(32'(cur_submode), 32'(MSTC_SUBM_EXC));
      pulse('{int_valid: 1'b1, default: '0});
      check(32'(cur_submode), 32'(MSTC_SUBM_INT));
      // Software switches the sub-mode back to normal by a register write.
      bus(1'b1, MSTC_ADDR_SUBM_B, 32'h0000_0000, 4'h3);
      check(32'(cur_submode), 32'(MSTC_SUBM_NORMAL));
      rd(6'h24);
      check(q, 32'h0);
      // A second reset in mid-run, taken from the interrupt sub-mode.
      pulse('{int_valid: 1'b1, default: '0});
      reset_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      check(32'(cur_submode), 32'(MSTC_SUBM_NORMAL));
      check(32'(priv_mode), 32'(MSTC_PRIV_M));
      check(32'(redirect.valid), 32'h0);
      rd(MSTC_ADDR_SUBM_B);
      check(q, 32'h0);
      close_out();
   end
endmodule : tb
`default_nettype wire
